// [logic/sram_ctl_defs.vh]
// timing counts and widths for the asynchronous bit sram controller
`ifndef SRAM_CTL_DEFS_VH
`define SRAM_CTL_DEFS_VH
`define CLK_PERIOD_NS      40
`define ADDR_W             14
`define ACCESS_TIME_NS     55
`define ACCESS_CYC ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS     25
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_SETUP_NS      20
`define DATA_SETUP_CYC ((`DATA_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HZ_TIME_NS         25
`define HZ_CYC ((`HZ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W              4
`endif

// [logic/cycle_timer.v]
// down counter that marks when a programmed wait has run out
`timescale 1ns/1ps
module cycle_timer #(
  parameter W = 4
) (
  input  wire         core_clk,  // system clock
  input  wire         sys_rst,   // synchronous reset
  input  wire         load,      // start a new wait
  input  wire [W-1:0] count,     // cycles to wait
  output wire         done       // wait has elapsed
);
  reg [W-1:0] left;  // cycles remaining

  // load or count down to zero
  always @(posedge core_clk) begin
    if (sys_rst) begin
      left <= {W{1'b0}};
    end else if (load) begin
      left <= count;
    end else if (left != {W{1'b0}}) begin
      left <= left - {{(W-1){1'b0}}, 1'b1};
    end
  end

  // done looks at the count alone; a load made because of done
  // must not feed back into done in the same cycle
  assign done = (left == {W{1'b0}});
endmodule // cycle_timer

// [logic/sram_ctl.v]
// controller that runs read and write cycles on a 16k x 1 async sram
`timescale 1ns/1ps
`include "sram_ctl_defs.vh"

module sram_ctl #(
  parameter ADDR_W    = `ADDR_W,          // cell address width
  parameter CNT_W     = `CNT_W,           // timer width
  parameter ACC_CYC   = `ACCESS_CYC,      // read access wait
  parameter WP_CYC    = `WRITE_PULSE_CYC, // write pulse length
  parameter HZ_CYC    = `HZ_CYC           // float wait after write
) (
  input  wire              core_clk,      // system clock
  input  wire              sys_rst,       // synchronous, active high
  input  wire              req_valid,     // user request present
  input  wire              req_write,     // 1 write, 0 read
  input  wire              req_end_by_sel,// write ends by select rising
  input  wire [ADDR_W-1:0] req_addr,      // cell to access
  input  wire              req_wdata,     // bit to write
  output wire              req_ready,     // request taken this cycle
  output reg               rsp_valid,     // read data pulse
  output reg               rsp_rdata,     // read data bit
  output reg  [ADDR_W-1:0] cell_address,  // sram address pins
  output reg               select_n,      // sram chip select, low active
  output reg               strobe_n,      // sram write strobe, low active
  output reg               data_in,       // sram data-in pin
  output reg               data_in_oe,    // drive enable for data-in
  input  wire              data_out       // sram data-out pin
);
  // one-hot states
  localparam [4:0] ST_IDLE  = 5'h01; // deselected standby
  localparam [4:0] ST_READ  = 5'h02; // waiting access time
  localparam [4:0] ST_WSET  = 5'h04; // select low, address set up
  localparam [4:0] ST_WPUL  = 5'h08; // strobe low, pulse running
  localparam [4:0] ST_WEND  = 5'h10; // write ended, bus settling
  // writes always start from idle, with select high for a cycle

  reg  [4:0]       state;      // current state
  reg  [4:0]       next_state; // next state
  reg              end_by_sel; // latched end style of write
  reg              t_load;     // start timer
  reg  [CNT_W-1:0] t_count;    // timer length
  wire             t_done;     // timer elapsed

  // request accepted only when idle or finishing a read;
  // a write waiting behind a read is left until idle, so
  // select goes high for a cycle before the strobe falls
  assign req_ready = (state == ST_IDLE) ||
                     ((state == ST_READ) && t_done && !req_write);

  // shared wait timer for access, pulse and float times;
  // one is enough since these waits never overlap
  cycle_timer #(.W(CNT_W)) u_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .load     (t_load),
    .count    (t_count),
    .done     (t_done)
  );

  // next state and timer load
  always @* begin
    next_state = state;
    t_load     = 1'b0;
    t_count    = {CNT_W{1'b0}};
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          t_load = 1'b1;
          if (req_write) begin
            next_state = ST_WSET;
            t_count    = {CNT_W{1'b0}};
          end else begin
            next_state = ST_READ;
            t_count    = ACC_CYC[CNT_W-1:0];
          end
        end
      end
      ST_READ: begin
        if (t_done) begin
          if (req_valid && !req_write) begin
            // back to back read under select
            t_load  = 1'b1;
            t_count = ACC_CYC[CNT_W-1:0];
          end else begin
            // a write behind the read waits for idle
            next_state = ST_IDLE;
          end
        end
      end
      ST_WSET: begin
        next_state = ST_WPUL;
        t_load     = 1'b1;
        t_count    = WP_CYC[CNT_W-1:0];
      end
      ST_WPUL: begin
        if (t_done) begin
          next_state = ST_WEND;
          t_load     = 1'b1;
          t_count    = HZ_CYC[CNT_W-1:0];
        end
      end
      ST_WEND: begin
        if (t_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  // sync reset: pins come out of reset deselected
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // pin drive
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cell_address <= {ADDR_W{1'b0}};
      select_n     <= 1'b1;
      strobe_n     <= 1'b1;
      data_in      <= 1'b0;
      data_in_oe   <= 1'b0;
      end_by_sel   <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_rdata    <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          select_n <= 1'b1;
          strobe_n <= 1'b1;
          if (req_valid) begin
            // address set on the same edge that select falls
            cell_address <= req_addr;
            select_n     <= 1'b0;
            end_by_sel   <= req_end_by_sel;
            if (req_write) begin
              data_in    <= req_wdata;
              data_in_oe <= 1'b1;
              // strobe falls with select: output off, except one ST_WEND cycle of a strobe-ended write
              strobe_n   <= 1'b0;
            end else begin
              strobe_n   <= 1'b1;
              data_in_oe <= 1'b0;
            end
          end
        end
        ST_READ: begin
          if (t_done) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= data_out;
            if (req_valid && !req_write) begin
              // select stays low, only address moves
              cell_address <= req_addr;
            end else begin
              // deselect; the next select fall is full speed again
              select_n <= 1'b1;
            end
          end
        end
        ST_WSET: begin
          // strobe held low; address and data stay put
          strobe_n <= 1'b0;
        end
        ST_WPUL: begin
          if (t_done) begin
            // data held through the ending edge
            if (end_by_sel) begin
              select_n <= 1'b1;
            end else begin
              strobe_n <= 1'b1;
            end
          end
        end
        ST_WEND: begin
          // release select and strobe, address unchanged
          // data keeps driving until the float wait is over
          select_n <= 1'b1;
          strobe_n <= 1'b1;
          if (t_done) begin
            data_in_oe <= 1'b0;
          end
        end
        default: begin
          select_n <= 1'b1;
          strobe_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // sram_ctl

// [verification/sram_cell_model.sv]
// behavioural 16k x 1 async sram on the far side of the controller
`timescale 1ns/1ps
module sram_cell_model #(
  parameter AW   = 14, // address width
  parameter TACC = 50  // access delay in ns
) (
  input  wire          sel_n, // chip select, low active
  input  wire          stb_n, // write strobe, low active
  input  wire [AW-1:0] adr,   // cell address
  input  wire          d,     // data in
  output wire          q      // data out
);
  reg     mem [0:(1<<AW)-1]; // bit cells
  integer i;                 // fill index
  wire    on;                // output buffer enabled
  // known start pattern: address parity
  initial for (i = 0; i < (1<<AW); i = i + 1) mem[i] = ^i[AW-1:0];
  // store on whichever edge ends the write
  always @(posedge stb_n) if (!sel_n) mem[adr] <= d;
  always @(posedge sel_n) if (!stb_n) mem[adr] <= d;
  assign on = !sel_n && stb_n;
  // slow access, floating output shows garbage
  assign #TACC q = on ? mem[adr] : ~mem[adr];
endmodule // sram_cell_model

// [verification/sram_ctl_asserts.sv]
// port assertions for the async sram controller
`timescale 1ns/1ps
module sram_ctl_asserts #(
  parameter ADDR_W = 14 // cell address width
) (
  input wire              core_clk,
  input wire              sys_rst,
  input wire              req_valid,
  input wire              req_write,
  input wire              req_ready,
  input wire [ADDR_W-1:0] req_addr,
  input wire              req_wdata,
  input wire              rsp_valid,
  input wire [ADDR_W-1:0] cell_address,
  input wire              select_n,
  input wire              strobe_n,
  input wire              data_in,
  input wire              data_in_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd; req_valid && req_ready && !req_write; endsequence
  sequence s_wr; req_valid && req_ready && req_write; endsequence
  property p_rd_pins;
    s_rd |=> !select_n && strobe_n && cell_address == $past(req_addr);
  endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("read pins");
  property p_rd_lat; s_rd |-> ##4 rsp_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read late");
  property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("rsp long");
  property p_no_stb; !select_n && $past(!select_n) |-> !$fell(strobe_n);
  endproperty
  a_no_stb: assert property (p_no_stb) else $error("strobe in read");
  property p_wr_pins;
    s_wr |=> !select_n && !strobe_n && data_in_oe
      && data_in == $past(req_wdata);
  endproperty
  a_wr_pins: assert property (p_wr_pins) else $error("write pins");
  property p_wr_busy; s_wr |=> !req_ready; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("took in write");
  property p_adr_hold;
    !select_n && !strobe_n && $past(!select_n && !strobe_n)
      |-> $stable(cell_address);
  endproperty
  a_adr_hold: assert property (p_adr_hold) else $error("addr moved");
  property p_stb_end;
    $rose(strobe_n) && !select_n |-> data_in_oe && $stable(data_in);
  endproperty
  a_stb_end: assert property (p_stb_end) else $error("data at stb");
  property p_sel_end;
    $rose(select_n) && $past(!strobe_n) |-> data_in_oe && $stable(data_in);
  endproperty
  a_sel_end: assert property (p_sel_end) else $error("data at sel");
  property p_wr_len; $fell(strobe_n) |-> ##[1:8] strobe_n; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write hung");
endmodule // sram_ctl_asserts
bind sram_ctl sram_ctl_asserts #(.ADDR_W(ADDR_W)) chk_u (.core_clk,
  .sys_rst, .req_valid, .req_write, .req_ready, .req_addr, .req_wdata,
  .rsp_valid, .cell_address, .select_n, .strobe_n, .data_in, .data_in_oe);

// [verification/sram_ctl_bench.sv]
// self-checking bench for the async sram controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module sram_ctl_bench;
  reg        core_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0;
  reg        req_end_by_sel = 0, req_wdata = 0;
  reg [13:0] req_addr = 14'h0000;
  wire       req_ready, rsp_valid, rsp_rdata, select_n, strobe_n;
  wire       data_in, data_in_oe, data_out;
  wire [13:0] cell_address;
  integer    errors = 0, n_compared = 0;
  sram_ctl dut_u (.core_clk, .sys_rst, .req_valid, .req_write,
    .req_end_by_sel, .req_addr, .req_wdata, .req_ready, .rsp_valid,
    .rsp_rdata, .cell_address, .select_n, .strobe_n, .data_in,
    .data_in_oe, .data_out);
  sram_cell_model mem_u (.sel_n(select_n), .stb_n(strobe_n),
    .adr(cell_address), .d(data_in_oe ? data_in : ~data_in), .q(data_out));
  initial forever #20 core_clk = ~core_clk;
  // one request, held until taken; reads wait for the answer
  task xfer(input w, e, input [13:0] a, input d, output r);
    integer n;
    begin
      n = 0;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_end_by_sel <= e;
      req_addr <= a;
      req_wdata <= d;
      do begin
        @(negedge core_clk);
        r = req_ready;
        @(posedge core_clk);
        n = n + 1;
      end while (r !== 1'b1 && n < 40);
      `CHK("taken", 1'b1, r)
      req_valid <= 1'b0;
      while (!w && rsp_valid !== 1'b1 && n < 80) begin
        @(negedge core_clk);
        n = n + 1;
      end
      r = rsp_rdata;
      `CHK("handshake", 1'b1, n < 80)
    end
  endtask
  task t_reset;
    begin
      @(negedge core_clk);
      `CHK("idle pins", 4'hC, {select_n, strobe_n, data_in_oe, rsp_valid})
      $display("done reset");
    end
  endtask
  task t_write_back(input e);
    integer i;
    reg [13:0] a;
    reg r;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        a = (i == 0 ? 14'h0000 : i == 1 ? 14'h3FFF : 14'h1555);
        a = a ^ {5'h00, e, 8'h00};
        xfer(1'b0, 1'b0, a, 1'b0, r);
        `CHK("initial", ^a, r)
        xfer(1'b1, e, a, ~^a, r);
        xfer(1'b0, 1'b0, a, 1'b0, r);
        `CHK("read back", ~^a, r)
        xfer(1'b0, 1'b0, a ^ 14'h0001, 1'b0, r);
        `CHK("neighbour", ^(a ^ 14'h0001), r)
      end
      $display("done write back %0d", e);
    end
  endtask
  // three reads with select held low, address moved at the first two takes
  task t_burst(input [13:0] a);
    integer k, n, got;
    reg rdy;
    reg [13:0] b;
    begin
      k = 0;
      n = 0;
      got = 0;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= 1'b0;
      req_addr <= a;
      while (got < 3 && n < 40) begin
        @(negedge core_clk);
        rdy = req_ready;
        if (rsp_valid === 1'b1) begin
          b = a + got[13:0];
          `CHK("burst data", ^b, rsp_rdata)
          got = got + 1;
        end else if (k > 0) begin
          `CHK("burst select", 1'b0, select_n)
        end
        @(posedge core_clk);
        n = n + 1;
        if (rdy === 1'b1 && k < 3) begin
          k = k + 1;
          if (k == 3)
            req_valid <= 1'b0;
          else
            req_addr <= a + k[13:0];
        end
      end
      `CHK("burst count", 3, got)
      $display("done burst");
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_write_back(1'b0);
    t_write_back(1'b1);
    t_burst(14'h2A00);
    finish_test;
  end
  initial begin
    #400000;
    errors = errors + 1;
    finish_test;
  end
endmodule // sram_ctl_bench
